// ===== eqs_pkg.sv
package eqs_pkg;

	// register indices; byte address is four times the index
	localparam logic [11:0] IDX_QUEUE_INDEX   = 12'h900;
	localparam logic [11:0] IDX_QUEUE_CONTROL = 12'h914;
	localparam logic [11:0] IDX_RR_WEIGHT     = 12'h915;
	localparam logic [11:0] IDX_HIGH_WATER    = 12'h916;
	localparam logic [11:0] IDX_LOW_WATER     = 12'h918;
	localparam logic [11:0] IDX_INCREMENT     = 12'h91A;
	localparam logic [11:0] IDX_PORT_CTL_ZERO = 12'hA00;
	localparam logic [11:0] IDX_MEMBERSHIP    = 12'hA04;
	localparam logic [11:0] IDX_TXQ_MEMORY    = 12'hA10;

	// reset values
	localparam logic [6:0]  RST_RR_WEIGHT  = 7'h01;
	localparam logic [15:0] RST_HIGH_WATER = 16'h0534;
	localparam logic [15:0] RST_LOW_WATER  = 16'h05F2;
	localparam logic [15:0] RST_INCREMENT  = 16'h2000;
	localparam logic [31:0] RST_MEMBERSHIP = 32'h0000_0007;
	localparam logic [1:0]  RST_SCHED_MODE = 2'h2;
	localparam logic [1:0]  RST_SHAPE_MODE = 2'h0;
	localparam logic [1:0]  RST_QUEUE_IDX  = 2'h0;
	localparam logic [10:0] RST_BLOCKS     = 11'h000;

	// field positions in the queue control register
	localparam int SCHED_MODE_LSB = 6;
	localparam int SHAPE_MODE_LSB = 4;

	// mode encodings
	localparam logic [1:0] SCHED_STRICT = 2'h0;
	localparam logic [1:0] SCHED_WRR    = 2'h2;
	localparam logic [1:0] SHAPE_NONE   = 2'h0;
	localparam logic [1:0] SHAPE_CBS    = 2'h1;

	// AXI responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// credit fixed point: fraction bits below the byte
	localparam int CREDIT_FRAC = 16;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_BUSY = 2'b10
	} eqs_state_t;

endpackage

// ===== eqs_regs.sv
`timescale 1ns/100ps
module eqs_regs #(
	parameter int NQ       = 4,
	parameter int ADDR_W   = 14,
	parameter int BLOCKS_W = 11
) (
	input  wire logic                aclk,
	input  wire logic                aresetn,
	input  wire logic                ce,
	input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
	input  wire logic                s_axi_awvalid,
	output logic                     s_axi_awready,
	input  wire logic [31:0]         s_axi_wdata,
	input  wire logic [3:0]          s_axi_wstrb,
	input  wire logic                s_axi_wvalid,
	output logic                     s_axi_wready,
	output logic [1:0]               s_axi_bresp,
	output logic                     s_axi_bvalid,
	input  wire logic                s_axi_bready,
	input  wire logic [ADDR_W-1:0]   s_axi_araddr,
	input  wire logic                s_axi_arvalid,
	output logic                     s_axi_arready,
	output logic [31:0]              s_axi_rdata,
	output logic [1:0]               s_axi_rresp,
	output logic                     s_axi_rvalid,
	input  wire logic                s_axi_rready,
	input  wire logic                single_queue,
	input  wire logic [NQ-1:0]       queue_ready,
	output logic                     tx_grant_valid,
	output logic [1:0]               tx_grant_queue,
	input  wire logic                tx_done,
	input  wire logic [15:0]         tx_bytes,
	output logic [2:0]               fwd_allow,
	input  wire logic                blk_alloc,
	input  wire logic                blk_free
);

	localparam logic [BLOCKS_W-1:0] BLK_MAX = '1;

	logic                  aw_hold_r;
	logic                  w_hold_r;
	logic [ADDR_W-1:0]     awaddr_r;
	logic [31:0]           wdata_r;
	logic [3:0]            wstrb_r;
	logic                  bvalid_r;
	logic [1:0]            bresp_r;
	logic                  rvalid_r;
	logic [31:0]           rdata_r;
	logic [1:0]            rresp_r;
	logic [11:0]           rd_idx_r;
	logic                  wr_fire;
	logic [11:0]           wr_idx;
	logic [11:0]           ar_idx;
	logic                  wr_hit;
	logic                  rd_hit;
	logic [31:0]           rd_data_nxt;
	logic [1:0]            qidx_r;
	logic [6:0]            weight_r [NQ];
	logic [15:0]           high_r   [NQ];
	logic [15:0]           low_r    [NQ];
	logic [15:0]           inc_r    [NQ];
	logic [1:0]            sched_r  [NQ];
	logic [1:0]            shape_r  [NQ];
	logic signed [33:0]    credit_r [NQ];
	logic [31:0]           memb_r;
	logic [BLOCKS_W-1:0]   blocks_r;
	eqs_pkg::eqs_state_t   state_r;
	logic [1:0]            grant_q_r;
	logic                  grant_v_r;
	logic [1:0]            rr_ptr_r;
	logic [6:0]            rr_cnt_r;
	logic [NQ-1:0]         elig;
	logic                  wrr_mode;
	logic                  pick_any;
	logic [1:0]            pick_q;
	logic                  pick_same;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++)
		begin
			if (strb[b])
				res[8*b +: 8] = nw[8*b +: 8];
		end
		return res;
	endfunction

	function automatic logic map_hit(input logic [11:0] idx);
		return idx == eqs_pkg::IDX_QUEUE_INDEX || idx == eqs_pkg::IDX_QUEUE_CONTROL
			|| idx == eqs_pkg::IDX_RR_WEIGHT || idx == eqs_pkg::IDX_HIGH_WATER
			|| idx == eqs_pkg::IDX_LOW_WATER || idx == eqs_pkg::IDX_INCREMENT
			|| idx == eqs_pkg::IDX_PORT_CTL_ZERO || idx == eqs_pkg::IDX_MEMBERSHIP
			|| idx == eqs_pkg::IDX_TXQ_MEMORY;
	endfunction

	// write path: address and data captured in either order
	assign s_axi_awready = !aw_hold_r && !bvalid_r;
	assign s_axi_wready  = !w_hold_r && !bvalid_r;
	assign s_axi_bvalid  = bvalid_r;
	assign s_axi_bresp   = bresp_r;
	assign wr_fire       = aw_hold_r && w_hold_r && !bvalid_r;
	assign wr_idx        = 12'(awaddr_r >> 2);
	assign wr_hit        = map_hit(wr_idx);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_hold_r <= 1'b0;
			w_hold_r  <= 1'b0;
			awaddr_r  <= '0;
			wdata_r   <= 32'h0000_0000;
			wstrb_r   <= 4'h0;
			bvalid_r  <= 1'b0;
			bresp_r   <= eqs_pkg::RESP_OKAY;
		end
		else if (ce)
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_hold_r <= 1'b1;
				awaddr_r  <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_hold_r <= 1'b1;
				wdata_r  <= s_axi_wdata;
				wstrb_r  <= s_axi_wstrb;
			end
			if (wr_fire)
			begin
				aw_hold_r <= 1'b0;
				w_hold_r  <= 1'b0;
				bvalid_r  <= 1'b1;
				bresp_r   <= wr_hit ? eqs_pkg::RESP_OKAY : eqs_pkg::RESP_SLVERR;
			end
			else if (bvalid_r && s_axi_bready)
				bvalid_r <= 1'b0;
		end
	end

	// port level registers
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			qidx_r <= eqs_pkg::RST_QUEUE_IDX;
			memb_r <= eqs_pkg::RST_MEMBERSHIP;
		end
		else if (ce && wr_fire)
		begin
			if (wr_idx == eqs_pkg::IDX_QUEUE_INDEX && wstrb_r[0])
				qidx_r <= wdata_r[1:0];
			if (wr_idx == eqs_pkg::IDX_MEMBERSHIP)
				memb_r <= merge(memb_r, wdata_r, wstrb_r);
		end
	end

	// membership gates forwarding with no tag input at all
	assign fwd_allow = memb_r[2:0];

	// live block count, held at zero with nothing queued
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			blocks_r <= eqs_pkg::RST_BLOCKS;
		else if (ce && (blk_alloc != blk_free))
		begin
			if (blk_alloc && blocks_r != BLK_MAX)
				blocks_r <= blocks_r + 1'b1;
			else if (blk_free && blocks_r != '0)
				blocks_r <= blocks_r - 1'b1;
		end
	end

	// per queue configuration and credit
	for (genvar q = 0; q < NQ; q++)
	begin : g_queue
		logic sel_wr;
		logic sending;
		logic signed [33:0] hi_lim;
		logic signed [33:0] lo_lim;
		logic signed [33:0] grown;
		logic signed [33:0] spent;

		assign sel_wr  = wr_fire && qidx_r == 2'(q) && wstrb_r[0];
		assign sending = grant_v_r && grant_q_r == 2'(q);
		assign hi_lim  = $signed({2'b00, high_r[q], 16'h0000});
		assign lo_lim  = -$signed({2'b00, low_r[q], 16'h0000});
		assign grown   = credit_r[q] + $signed({18'h00000, inc_r[q]});
		assign spent   = credit_r[q] - $signed({2'b00, tx_bytes, 16'h0000});

		always_ff @(posedge aclk)
		begin
			if (!aresetn)
			begin
				weight_r[q] <= eqs_pkg::RST_RR_WEIGHT;
				high_r[q]   <= eqs_pkg::RST_HIGH_WATER;
				low_r[q]    <= eqs_pkg::RST_LOW_WATER;
				inc_r[q]    <= eqs_pkg::RST_INCREMENT;
				sched_r[q]  <= eqs_pkg::RST_SCHED_MODE;
				shape_r[q]  <= eqs_pkg::RST_SHAPE_MODE;
			end
			else if (ce && sel_wr)
			begin
				unique case (wr_idx)
					eqs_pkg::IDX_RR_WEIGHT:
						weight_r[q] <= wdata_r[6:0];
					eqs_pkg::IDX_QUEUE_CONTROL:
					begin
						sched_r[q] <= wdata_r[eqs_pkg::SCHED_MODE_LSB +: 2];
						shape_r[q] <= wdata_r[eqs_pkg::SHAPE_MODE_LSB +: 2];
					end
					eqs_pkg::IDX_HIGH_WATER:
						high_r[q] <= 16'(merge({16'h0000, high_r[q]}, wdata_r, wstrb_r));
					eqs_pkg::IDX_LOW_WATER:
						low_r[q] <= 16'(merge({16'h0000, low_r[q]}, wdata_r, wstrb_r));
					eqs_pkg::IDX_INCREMENT:
						inc_r[q] <= 16'(merge({16'h0000, inc_r[q]}, wdata_r, wstrb_r));
					default:
						;
				endcase
			end
		end

		// credit: grows while waiting, drains by frame size, clamped
		always_ff @(posedge aclk)
		begin
			if (!aresetn)
				credit_r[q] <= '0;
			else if (ce)
			begin
				if (shape_r[q] != eqs_pkg::SHAPE_CBS)
					credit_r[q] <= '0;
				else if (sending && tx_done)
					credit_r[q] <= (spent < lo_lim) ? lo_lim : spent;
				else if (queue_ready[q] && !sending)
					credit_r[q] <= (grown > hi_lim) ? hi_lim : grown;
				else if (!queue_ready[q] && credit_r[q] > 0)
					credit_r[q] <= '0;
			end
		end

		assign elig[q] = queue_ready[q] && (q == 0 || !single_queue)
			&& (shape_r[q] != eqs_pkg::SHAPE_CBS || credit_r[q] >= 0);

		a_credit_bound: assert property (@(posedge aclk) disable iff (!aresetn)
			credit_r[q] <= hi_lim && credit_r[q] >= lo_lim)
			else $error("queue credit left its water marks");
		a_no_shape_zero: assert property (@(posedge aclk) disable iff (!aresetn)
			ce && shape_r[q] != eqs_pkg::SHAPE_CBS |=> credit_r[q] == 0)
			else $error("credit moved without credit shaping");
	end

	// scheduler choice
	always_comb
	begin
		wrr_mode  = !single_queue && sched_r[rr_ptr_r] == eqs_pkg::SCHED_WRR;
		pick_same = wrr_mode && elig[rr_ptr_r] && rr_cnt_r < weight_r[rr_ptr_r];
		pick_any  = |elig;
		pick_q    = 2'h0;
		if (pick_same)
			pick_q = rr_ptr_r;
		else if (wrr_mode)
		begin
			for (int i = NQ; i >= 1; i--)
			begin
				if (elig[2'(rr_ptr_r + 2'(i))])
					pick_q = 2'(rr_ptr_r + 2'(i));
			end
		end
		else
		begin
			for (int i = 0; i < NQ; i++)
			begin
				if (elig[i])
					pick_q = 2'(i);
			end
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state_r   <= eqs_pkg::ST_IDLE;
			grant_v_r <= 1'b0;
			grant_q_r <= 2'h0;
			rr_ptr_r  <= 2'h0;
			rr_cnt_r  <= 7'h00;
		end
		else if (ce)
		begin
			unique case (state_r)
				eqs_pkg::ST_IDLE:
				begin
					if (pick_any)
					begin
						state_r   <= eqs_pkg::ST_BUSY;
						grant_v_r <= 1'b1;
						grant_q_r <= pick_q;
						rr_ptr_r  <= pick_q;
						rr_cnt_r  <= pick_same ? rr_cnt_r + 7'h01 : 7'h01;
					end
				end
				eqs_pkg::ST_BUSY:
				begin
					if (tx_done)
					begin
						state_r   <= eqs_pkg::ST_IDLE;
						grant_v_r <= 1'b0;
					end
				end
			endcase
		end
	end

	assign tx_grant_valid = grant_v_r;
	assign tx_grant_queue = grant_q_r;

	// read path
	assign ar_idx        = 12'(s_axi_araddr >> 2);
	assign rd_hit        = map_hit(ar_idx);
	assign s_axi_arready = !rvalid_r;
	assign s_axi_rvalid  = rvalid_r;
	assign s_axi_rdata   = rdata_r;
	assign s_axi_rresp   = rresp_r;

	always_comb
	begin
		rd_data_nxt = 32'h0000_0000;
		unique case (ar_idx)
			eqs_pkg::IDX_QUEUE_INDEX:
				rd_data_nxt[1:0] = qidx_r;
			eqs_pkg::IDX_QUEUE_CONTROL:
				rd_data_nxt[7:4] = {sched_r[qidx_r], shape_r[qidx_r]};
			eqs_pkg::IDX_RR_WEIGHT:
				rd_data_nxt[6:0] = weight_r[qidx_r];
			eqs_pkg::IDX_HIGH_WATER:
				rd_data_nxt[15:0] = high_r[qidx_r];
			eqs_pkg::IDX_LOW_WATER:
				rd_data_nxt[15:0] = low_r[qidx_r];
			eqs_pkg::IDX_INCREMENT:
				rd_data_nxt[15:0] = inc_r[qidx_r];
			eqs_pkg::IDX_MEMBERSHIP:
				rd_data_nxt = memb_r;
			eqs_pkg::IDX_TXQ_MEMORY:
				rd_data_nxt[BLOCKS_W-1:0] = blocks_r;
			default:
				rd_data_nxt = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid_r <= 1'b0;
			rdata_r  <= 32'h0000_0000;
			rresp_r  <= eqs_pkg::RESP_OKAY;
			rd_idx_r <= 12'h000;
		end
		else if (ce)
		begin
			if (s_axi_arvalid && s_axi_arready)
			begin
				rvalid_r <= 1'b1;
				rdata_r  <= rd_data_nxt;
				rresp_r  <= rd_hit ? eqs_pkg::RESP_OKAY : eqs_pkg::RESP_SLVERR;
				rd_idx_r <= ar_idx;
			end
			else if (rvalid_r && s_axi_rready)
				rvalid_r <= 1'b0;
		end
	end

	sequence s_both_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && ce;
	endsequence

	sequence s_qidx_write;
		ce && wr_fire && wr_idx == eqs_pkg::IDX_QUEUE_INDEX && wstrb_r[0];
	endsequence

	a_write_answer: assert property (@(posedge aclk) disable iff (!aresetn)
		s_both_taken ##1 ce |=> s_axi_bvalid)
		else $error("write not answered two cycles after capture");
	a_qidx_select: assert property (@(posedge aclk) disable iff (!aresetn)
		s_qidx_write |=> qidx_r == $past(wdata_r[1:0]))
		else $error("queue index not loaded");
	a_weight_bit7: assert property (@(posedge aclk) disable iff (!aresetn)
		rvalid_r && rd_idx_r == eqs_pkg::IDX_RR_WEIGHT |-> rdata_r[31:7] == 25'h0)
		else $error("weight upper bits not zero");
	a_wrr_limit: assert property (@(posedge aclk) disable iff (!aresetn)
		grant_v_r && wrr_mode |-> rr_cnt_r <= weight_r[rr_ptr_r] || weight_r[rr_ptr_r] == 7'h00)
		else $error("round robin exceeded weight");
	a_single_q: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && single_queue && state_r == eqs_pkg::ST_IDLE && pick_any |=> tx_grant_queue == 2'h0)
		else $error("single queue granted other queue");
	a_cbs_gate: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && state_r == eqs_pkg::ST_IDLE && pick_any
		&& shape_r[pick_q] == eqs_pkg::SHAPE_CBS |-> credit_r[pick_q] >= 0)
		else $error("queue sent with negative credit");
	a_memb_write: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && wr_fire && wr_idx == eqs_pkg::IDX_MEMBERSHIP && wstrb_r[0]
		|=> fwd_allow == $past(wdata_r[2:0]))
		else $error("membership write not forwarded");
	a_blk_count: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && blk_alloc && !blk_free && blocks_r != BLK_MAX |=> blocks_r == $past(blocks_r) + 1'b1)
		else $error("block count did not grow");

endmodule // eqs_regs

// ===== eqs_regs_tb_top.sv
`timescale 1ns/100ps
module eqs_regs_tb_top;
	logic        aclk;
	logic        aresetn;
	logic [13:0] awaddr;
	logic        awvalid;
	logic        awready;
	logic [31:0] wdata;
	logic        wvalid;
	logic        wready;
	logic [1:0]  bresp;
	logic        bvalid;
	logic        bready;
	logic [13:0] araddr;
	logic        arvalid;
	logic        arready;
	logic [31:0] rdata;
	logic [1:0]  rresp;
	logic        rvalid;
	logic        rready;
	logic        single_queue;
	logic [3:0]  queue_ready;
	logic        grant_valid;
	logic [1:0]  grant_queue;
	logic        tx_done;
	logic [15:0] tx_bytes;
	logic [2:0]  fwd_allow;
	logic        blk_alloc;
	logic        blk_free;
	int          fails;
	int          cmp_count;

	eqs_regs eqs_regs_inst (
		.aclk(aclk), .aresetn(aresetn), .ce(1'b1),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .single_queue(single_queue),
		.queue_ready(queue_ready), .tx_grant_valid(grant_valid),
		.tx_grant_queue(grant_queue), .tx_done(tx_done), .tx_bytes(tx_bytes),
		.fwd_allow(fwd_allow), .blk_alloc(blk_alloc), .blk_free(blk_free)
	);

	initial
	begin
		aclk = 1'b0;
		forever #12.5 aclk = ~aclk;
	end

	task chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
			fails++;
		end
	endtask

	task end_sim;
		$display("compares=%0d mismatches=%0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic wr(input logic [11:0] idx, input logic [31:0] d, input logic [1:0] er);
		int         n;
		logic       aw_hs;
		logic       w_hs;
		logic       done;
		logic [1:0] r;
		n = 0;
		done = 1'b0;
		r = 2'h3;
		@(posedge aclk);
		awaddr <= {idx, 2'b00};
		awvalid <= 1'b1;
		wdata <= d;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!done && n < 100)
		begin
			@(negedge aclk);
			aw_hs = awvalid && awready;
			w_hs = wvalid && wready;
			if (bvalid === 1'b1)
				r = bresp;
			@(posedge aclk);
			if (aw_hs)
				awvalid <= 1'b0;
			if (w_hs)
				wvalid <= 1'b0;
			if (r !== 2'h3)
			begin
				bready <= 1'b0;
				done = 1'b1;
			end
			n++;
		end
		chk({30'h0, r}, {30'h0, er});
	endtask

	task automatic rq(input logic [11:0] idx, input logic [31:0] exp, input logic [1:0] er);
		int          n;
		logic        done;
		logic [31:0] d;
		logic [1:0]  r;
		logic        ar_hs;
		n = 0;
		done = 1'b0;
		d = 32'hXXXX_XXXX;
		r = 2'h3;
		@(posedge aclk);
		araddr <= {idx, 2'b00};
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!done && n < 100)
		begin
			@(negedge aclk);
			ar_hs = arvalid && arready;
			if (rvalid === 1'b1)
			begin
				d = rdata;
				r = rresp;
				done = 1'b1;
			end
			@(posedge aclk);
			if (ar_hs)
				arvalid <= 1'b0;
			if (done)
				rready <= 1'b0;
			n++;
		end
		chk(d, exp);
		chk({30'h0, r}, {30'h0, er});
	endtask

	// wait for a grant, then finish that frame; stop drops all requests
	task automatic serve(input logic [15:0] bytes, input logic stop, output logic [1:0] q,
			output int wt);
		wt = 0;
		@(negedge aclk);
		while (grant_valid !== 1'b1 && wt < 1000)
		begin
			@(negedge aclk);
			wt++;
		end
		q = grant_queue;
		@(posedge aclk);
		tx_done <= 1'b1;
		tx_bytes <= bytes;
		if (stop)
			queue_ready <= 4'h0;
		@(posedge aclk);
		tx_done <= 1'b0;
	endtask

	task t_reset;
		chk({29'h0, fwd_allow}, 32'h0000_0007);
		rq(eqs_pkg::IDX_QUEUE_INDEX, 32'h0, eqs_pkg::RESP_OKAY);
		for (int q = 0; q < 4; q++)
		begin
			wr(eqs_pkg::IDX_QUEUE_INDEX, 32'(q), eqs_pkg::RESP_OKAY);
			rq(eqs_pkg::IDX_RR_WEIGHT, 32'h0000_0001, eqs_pkg::RESP_OKAY);
			rq(eqs_pkg::IDX_HIGH_WATER, 32'h0000_0534, eqs_pkg::RESP_OKAY);
			rq(eqs_pkg::IDX_LOW_WATER, 32'h0000_05F2, eqs_pkg::RESP_OKAY);
			rq(eqs_pkg::IDX_INCREMENT, 32'h0000_2000, eqs_pkg::RESP_OKAY);
		end
		rq(eqs_pkg::IDX_MEMBERSHIP, 32'h0000_0007, eqs_pkg::RESP_OKAY);
		rq(eqs_pkg::IDX_TXQ_MEMORY, 32'h0000_0000, eqs_pkg::RESP_OKAY);
	endtask

	// each queue keeps its own copy; bit 7 of the weight never sticks
	task t_perq;
		for (int q = 0; q < 4; q++)
		begin
			wr(eqs_pkg::IDX_QUEUE_INDEX, 32'(q), eqs_pkg::RESP_OKAY);
			wr(eqs_pkg::IDX_RR_WEIGHT, 32'h80 + 32'(q + 2), eqs_pkg::RESP_OKAY);
			wr(eqs_pkg::IDX_HIGH_WATER, 32'h1000 + 32'(q), eqs_pkg::RESP_OKAY);
			wr(eqs_pkg::IDX_LOW_WATER, 32'hC000 + 32'(q), eqs_pkg::RESP_OKAY);
			wr(eqs_pkg::IDX_INCREMENT, 32'h0100 + 32'(q), eqs_pkg::RESP_OKAY);
		end
		for (int q = 0; q < 4; q++)
		begin
			wr(eqs_pkg::IDX_QUEUE_INDEX, 32'(q), eqs_pkg::RESP_OKAY);
			rq(eqs_pkg::IDX_RR_WEIGHT, 32'(q + 2), eqs_pkg::RESP_OKAY);
			rq(eqs_pkg::IDX_HIGH_WATER, 32'h1000 + 32'(q), eqs_pkg::RESP_OKAY);
			rq(eqs_pkg::IDX_LOW_WATER, 32'hC000 + 32'(q), eqs_pkg::RESP_OKAY);
			rq(eqs_pkg::IDX_INCREMENT, 32'h0100 + 32'(q), eqs_pkg::RESP_OKAY);
		end
	endtask

	task t_member;
		wr(eqs_pkg::IDX_MEMBERSHIP, 32'hFFFF_FFFA, eqs_pkg::RESP_OKAY);
		rq(eqs_pkg::IDX_MEMBERSHIP, 32'hFFFF_FFFA, eqs_pkg::RESP_OKAY);
		chk({29'h0, fwd_allow}, 32'h0000_0002);
		wr(eqs_pkg::IDX_MEMBERSHIP, 32'h0000_0005, eqs_pkg::RESP_OKAY);
		@(negedge aclk);
		chk({29'h0, fwd_allow}, 32'h0000_0005);
		wr(eqs_pkg::IDX_MEMBERSHIP, 32'h0000_0007, eqs_pkg::RESP_OKAY);
		wr(eqs_pkg::IDX_PORT_CTL_ZERO, 32'hFFFF_FFFF, eqs_pkg::RESP_OKAY);
		rq(eqs_pkg::IDX_PORT_CTL_ZERO, 32'h0, eqs_pkg::RESP_OKAY);
		wr(12'h901, 32'hFFFF_FFFF, eqs_pkg::RESP_SLVERR);
		rq(12'h901, 32'h0, eqs_pkg::RESP_SLVERR);
	endtask

	task t_blocks;
		@(posedge aclk);
		blk_alloc <= 1'b1;
		repeat (5) @(posedge aclk);
		blk_free <= 1'b1;
		repeat (2) @(posedge aclk);
		blk_alloc <= 1'b0;
		blk_free <= 1'b0;
		rq(eqs_pkg::IDX_TXQ_MEMORY, 32'h0000_0005, eqs_pkg::RESP_OKAY);
		@(posedge aclk);
		blk_free <= 1'b1;
		repeat (6) @(posedge aclk);
		blk_free <= 1'b0;
		rq(eqs_pkg::IDX_TXQ_MEMORY, 32'h0000_0000, eqs_pkg::RESP_OKAY);
	endtask

	// weights 2 and 3 from t_perq
	task t_wrr;
		logic [1:0] q;
		int         wt;
		logic [1:0] exp [6];
		exp = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h1, 2'h0};
		@(posedge aclk);
		queue_ready <= 4'b0011;
		for (int i = 0; i < 6; i++)
		begin
			serve(16'd64, i == 5, q, wt);
			chk({30'h0, q}, {30'h0, exp[i]});
		end
		@(posedge aclk);
		single_queue <= 1'b1;
		queue_ready <= 4'b0011;
		for (int i = 0; i < 3; i++)
		begin
			serve(16'd64, i == 2, q, wt);
			chk({30'h0, q}, 32'h0);
		end
		@(posedge aclk);
		single_queue <= 1'b0;
	endtask

	task t_strict_cbs;
		logic [1:0] q;
		int         wt;
		for (int i = 0; i < 4; i++)
		begin
			wr(eqs_pkg::IDX_QUEUE_INDEX, 32'(i), eqs_pkg::RESP_OKAY);
			wr(eqs_pkg::IDX_QUEUE_CONTROL, 32'h0, eqs_pkg::RESP_OKAY);
		end
		@(posedge aclk);
		queue_ready <= 4'b0101;
		for (int i = 0; i < 3; i++)
		begin
			serve(16'd64, i == 2, q, wt);
			chk({30'h0, q}, 32'h2);
			chk({31'h0, wt < 5}, 32'h1);
		end
		wr(eqs_pkg::IDX_QUEUE_INDEX, 32'h0, eqs_pkg::RESP_OKAY);
		wr(eqs_pkg::IDX_INCREMENT, 32'h2000, eqs_pkg::RESP_OKAY);
		wr(eqs_pkg::IDX_QUEUE_CONTROL, 32'h10, eqs_pkg::RESP_OKAY);
		@(posedge aclk);
		queue_ready <= 4'b0001;
		serve(16'd16, 1'b0, q, wt);
		chk({31'h0, wt < 5}, 32'h1);
		// 16 bytes owed at 1/8 byte a cycle is about 128 cycles
		serve(16'd16, 1'b1, q, wt);
		chk({31'h0, wt > 100 && wt < 200}, 32'h1);
	endtask

	initial
	begin
		repeat (20000) @(posedge aclk);
		fails++;
		end_sim();
	end

	initial
	begin
		fails = 0;
		cmp_count = 0;
		aresetn = 1'b0;
		awaddr = 14'h0;
		awvalid = 1'b0;
		wdata = 32'h0;
		wvalid = 1'b0;
		bready = 1'b0;
		araddr = 14'h0;
		arvalid = 1'b0;
		rready = 1'b0;
		single_queue = 1'b0;
		queue_ready = 4'h0;
		tx_done = 1'b0;
		tx_bytes = 16'h0;
		blk_alloc = 1'b0;
		blk_free = 1'b0;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset();
		t_perq();
		t_member();
		t_blocks();
		t_wrr();
		t_strict_cbs();
		end_sim();
	end
endmodule // eqs_regs_tb_top
